// ### hw/mcl_cell.sv
`timescale 1ns/100ps
// ==========================================================
// One configurable macrocell
module mcl_cell (
  input  wire logic                clk,        // Device clock
  input  wire logic                clr,        // Power-up clear
  input  wire logic [1:0]          cfg,        // Cell configuration
  input  wire logic                reg_ok,     // Registered mode active
  input  wire logic                d,          // Array sum term
  input  wire logic                pt_oe,      // Product-term enable
  input  wire logic                oe_n,       // Common enable pin
  input  wire logic                pl_en,      // Preload strobe
  input  wire logic                pl_val,     // Preload value
  input  wire logic                pin_i,      // Pad input level
  input  wire logic                pin_drv,    // Pad driven by board
  output logic                     q_ff,       // Register contents
  output logic                     pin_o_ff,   // Pad output
  output logic                     pin_oe_ff,  // Pad enable
  output logic                     fb          // Feedback to array
);

  logic is_reg;
  logic nxt_q;
  logic nxt_o;
  logic nxt_oe;

  // Registered only when the mode allows it
  assign is_reg = reg_ok && (cfg == 2'(mcl_pkg::MCL_CELL_REG));
  assign nxt_q  = pl_en ? pl_val : d;
  assign nxt_o  = is_reg ? ~nxt_q : d;
  // registered cell uses low enable pin
  assign nxt_oe = is_reg ? ~oe_n :
                  (cfg == 2'(mcl_pkg::MCL_CELL_IN))  ? 1'b0 :
                  (cfg == 2'(mcl_pkg::MCL_CELL_OUT)) ? 1'b1 : pt_oe;
  assign fb = pin_oe_ff ? pin_o_ff : (pin_drv ? pin_i : 1'b1);

  always_ff @(posedge clk) begin
    if (clr) begin
      q_ff      <= 1'b0;
      pin_o_ff  <= 1'b1;
      pin_oe_ff <= 1'b0;
    end else begin
      q_ff      <= is_reg ? nxt_q : 1'b0;
      pin_o_ff  <= nxt_o;
      pin_oe_ff <= nxt_oe;
    end
  end

endmodule : mcl_cell

// ### hw/mcl_pkg.sv
package mcl_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int          NUM_CELLS        = 8;
  localparam int          SIG_BYTES        = 8;
  localparam int          RST_INTERVAL_NS  = 1000;
  localparam int          CLK_PERIOD_NS    = 4;
  // Longest time rounds down
  localparam int          RST_CYCLES       = RST_INTERVAL_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Register map, word indices on the plain port
  localparam logic [3:0]  ADDR_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_CFG         = 4'h1;
  localparam logic [3:0]  ADDR_PRELOAD     = 4'h2;
  localparam logic [3:0]  ADDR_STATUS      = 4'h3;
  localparam logic [3:0]  ADDR_VERIFY      = 4'h4;
  localparam logic [3:0]  ADDR_SIG_BASE    = 4'h8;

  // CTRL bit positions
  localparam int          CTRL_FUSE_BIT    = 0;
  localparam int          CTRL_ERASE_BIT   = 1;
  localparam int          CTRL_MODE_LSB    = 4;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    MCL_MODE_SIMPLE     = 3'b001,
    MCL_MODE_COMPLEX    = 3'b010,
    MCL_MODE_REGISTERED = 3'b100
  } mcl_mode_e;

  typedef enum logic [1:0] {
    MCL_CELL_REG   = 2'h0,
    MCL_CELL_BIDIR = 2'h1,
    MCL_CELL_OUT   = 2'h2,
    MCL_CELL_IN    = 2'h3
  } mcl_cell_e;

  typedef enum logic [1:0] {
    MCL_ST_PWRUP = 2'b01,
    MCL_ST_RUN   = 2'b10
  } mcl_state_e;

  // One register-port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mcl_req_s;

  // Reset values
  localparam logic [15:0] CFG_RESET        = 16'h0000;
  localparam logic [7:0]  SIG_RESET        = 8'h00;
  localparam mcl_mode_e   MODE_RESET       = MCL_MODE_REGISTERED;

endpackage : mcl_pkg

// ### hw/mcl_top.sv
`timescale 1ns/100ps
// ==========================================================
// Macrocell configuration, preload, signature and fuse
module mcl_top #(
  parameter int N = mcl_pkg::NUM_CELLS      // Macrocell count
) (
  input  wire logic          clk,          // 250 MHz clock
  input  wire logic          rst,          // Power-up reset, high
  input  wire logic [3:0]    addr,         // Register index
  input  wire logic [7:0]    wdata,        // Write data
  input  wire logic          wr,           // Write strobe
  input  wire logic          rd,           // Read strobe
  output logic [7:0]         rdata_ff,     // Read data, next cycle
  input  wire logic [N-1:0]  sum_term,     // Array sum terms
  input  wire logic [N-1:0]  pt_oe,        // Product-term enables
  input  wire logic          oe_n,         // Common enable pin
  input  wire logic [N-1:0]  pin_i,        // Pad input levels
  input  wire logic [N-1:0]  pin_drv,      // Pads driven by board
  output logic [N-1:0]       pin_o_ff,     // Pad outputs
  output logic [N-1:0]       pin_oe_ff,    // Pad enables
  output logic [N-1:0]       fb_ff,        // Feedback to array
  output logic               ready_ff      // Reset interval over
);

  // ==========================================================
  // Declarations
  mcl_pkg::mcl_req_s   req;
  mcl_pkg::mcl_state_e st_ff;
  mcl_pkg::mcl_state_e nxt_st;
  mcl_pkg::mcl_mode_e  mode_ff;
  logic [15:0]         cfg_ff;
  logic [7:0]          sig_ff [mcl_pkg::SIG_BYTES];
  logic                fuse_ff;
  logic [9:0]          cnt_ff;
  logic [N-1:0]        q;
  logic [N-1:0]        fb;
  logic [N-1:0]        pl_en;
  logic                clr;
  logic                reg_ok;
  logic                wr_ctrl;
  logic                wr_cfg;
  logic                wr_pl;
  logic                wr_sig;
  logic                fuse_set;
  logic                erase;
  logic                mode_ok;
  logic [7:0]          rd_mux;
  logic [2:0]          sig_idx;

  // Decode of a register index against one exact index, all four bits compared
  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction : hit

  // ==========================================================
  // Request decode
  assign req      = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign wr_ctrl  = req.wr && hit(req.addr, mcl_pkg::ADDR_CTRL);
  assign wr_cfg   = req.wr && hit(req.addr, mcl_pkg::ADDR_CFG);
  assign wr_pl    = req.wr && hit(req.addr, mcl_pkg::ADDR_PRELOAD);
  assign wr_sig   = req.wr && req.addr[3];
  assign sig_idx  = req.addr[2:0];
  assign fuse_set = wr_ctrl && req.wdata[mcl_pkg::CTRL_FUSE_BIT];
  assign erase    = wr_ctrl && req.wdata[mcl_pkg::CTRL_ERASE_BIT];
  assign mode_ok  = $onehot(req.wdata[mcl_pkg::CTRL_MODE_LSB +: 3]);
  assign reg_ok   = (mode_ff == mcl_pkg::MCL_MODE_REGISTERED);
  assign clr      = rst || (st_ff == mcl_pkg::MCL_ST_PWRUP);
  assign pl_en    = (wr_pl && !fuse_ff && !fuse_set) ?
                    {N{1'b1}} : {N{1'b0}};

  // ==========================================================
  // Power-up sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      mcl_pkg::MCL_ST_PWRUP: begin
        if (cnt_ff == 10'(mcl_pkg::RST_CYCLES - 1)) begin
          nxt_st = mcl_pkg::MCL_ST_RUN;
        end
      end
      mcl_pkg::MCL_ST_RUN: nxt_st = mcl_pkg::MCL_ST_RUN;
      default: nxt_st = mcl_pkg::MCL_ST_PWRUP;
    endcase
  end

  // Interval counter; counts clock cycles, cells held clear meanwhile
  // interval length counted
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff    <= mcl_pkg::MCL_ST_PWRUP;
      cnt_ff   <= 10'h000;
      ready_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= (st_ff == mcl_pkg::MCL_ST_PWRUP) ? cnt_ff + 10'h001 : cnt_ff;
      ready_ff <= (nxt_st == mcl_pkg::MCL_ST_RUN);
    end
  end

  // ==========================================================
  // Configuration and fuse; fuse kept across reset, erase clears
  // fuse survives rst, erase only
  always_ff @(posedge clk) begin
    if (erase) begin
      fuse_ff <= 1'b0;
    end else if (fuse_set) begin
      fuse_ff <= 1'b1;
    end
  end

  // Mode and cell types; illegal mode writes ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= mcl_pkg::MODE_RESET;
      cfg_ff  <= mcl_pkg::CFG_RESET;
    end else begin
      if (wr_ctrl && mode_ok) begin
        mode_ff <= mcl_pkg::mcl_mode_e'(
                   req.wdata[mcl_pkg::CTRL_MODE_LSB +: 3]);
      end
      if (wr_cfg) begin
        cfg_ff <= {cfg_ff[7:0], req.wdata};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sig_ff <= '{default: mcl_pkg::SIG_RESET};
    end else if (wr_sig && !fuse_ff) begin
      sig_ff[sig_idx] <= req.wdata;
    end
  end

  // ==========================================================
  // Macrocells
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      mcl_cell u_cell (
        .clk       (clk),
        .clr       (clr),
        .cfg       (cfg_ff[2*(g%8) +: 2]),
        .reg_ok    (reg_ok),
        .d         (sum_term[g]),
        .pt_oe     (pt_oe[g]),
        .oe_n      (oe_n),
        .pl_en     (pl_en[g]),
        .pl_val    (req.wdata[g%8]),
        .pin_i     (pin_i[g]),
        .pin_drv   (pin_drv[g]),
        .q_ff      (q[g]),
        .pin_o_ff  (pin_o_ff[g]),
        .pin_oe_ff (pin_oe_ff[g]),
        .fb        (fb[g])
      );
    end
  endgenerate

  // Feedback retimed so every output is a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_ff <= {N{1'b1}};
    end else begin
      fb_ff <= fb;
    end
  end

  // ==========================================================
  // Read path; verify returns zero once secured
  // verify read gated by fuse
  assign rd_mux =
    req.addr[3]                              ? sig_ff[sig_idx] :
    hit(req.addr, mcl_pkg::ADDR_CTRL)        ?
      {1'b0, mode_ff, 3'h0, fuse_ff}                        :
    hit(req.addr, mcl_pkg::ADDR_CFG)         ?
      (fuse_ff ? 8'h00 : cfg_ff[7:0])                       :
    hit(req.addr, mcl_pkg::ADDR_STATUS)      ?
      {6'h00, fuse_ff, ready_ff}                            :
    hit(req.addr, mcl_pkg::ADDR_VERIFY)      ?
      (fuse_ff ? 8'h00 : 8'(q))                             :
    8'h00;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= req.rd ? rd_mux : 8'h00;
    end
  end

endmodule : mcl_top

// ### verification/mcl_board.sv
`timescale 1ns/100ps
// ==========================================================
// Board side of the pads: drivers plus weak pull-ups
module mcl_board #(
  parameter int N = 8  // Pad count
) (
  input  wire logic [N-1:0] drv_en,     // Board drives pad
  input  wire logic [N-1:0] drv_val,    // Board drive level
  input  wire logic [N-1:0] pin_o_ff,   // Device drive level
  input  wire logic [N-1:0] pin_oe_ff,  // Device drive enable
  output logic      [N-1:0] pin_i,      // Resolved pad level
  output logic      [N-1:0] pin_drv     // Pad driven by board
);
  // idle pads pulled high
  // Device drive wins so a fight never reads as a board level
  assign pin_i   = (pin_oe_ff & pin_o_ff) | (~pin_oe_ff & ~drv_en)
                 | (~pin_oe_ff & drv_en & drv_val);
  assign pin_drv = drv_en & ~pin_oe_ff;
endmodule : mcl_board

// ### verification/mcl_checker.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks for the macrocell block
module mcl_checker #(
  parameter int N = 8  // Cell count
) (
  input wire logic         clk,        // Clock
  input wire logic         rst,        // Reset
  input wire logic [3:0]   addr,       // Index
  input wire logic [7:0]   wdata,      // Write data
  input wire logic         wr,         // Write
  input wire logic         rd,         // Read
  input wire logic [7:0]   rdata_ff,   // Read data
  input wire logic [N-1:0] pin_o_ff,   // Pad out
  input wire logic [N-1:0] pin_oe_ff,  // Pad enable
  input wire logic [N-1:0] fb_ff,      // Feedback
  input wire logic         ready_ff    // Interval over
);
  // Shadow fuse; no reset, as it must survive one
  logic fuse_ff = 1'b0;
  wire  ctl_wr  = wr && addr == mcl_pkg::ADDR_CTRL;
  wire  rd_cfg  = rd && addr == mcl_pkg::ADDR_CFG;
  wire  rd_vfy  = rd && addr == mcl_pkg::ADDR_VERIFY;
  wire  rd_st   = rd && addr == mcl_pkg::ADDR_STATUS;
  always_ff @(posedge clk) begin
    if (ctl_wr) begin
      fuse_ff <= ~wdata[1] & (fuse_ff | wdata[0]);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  rst_high_a: assert property ($fell(rst) |-> &pin_o_ff && !ready_ff)
    else $error("pads not high after reset");
  rst_oe_a: assert property ($fell(rst) |-> pin_oe_ff == '0 && &fb_ff)
    else $error("pads enabled after reset");
  wait_len_a: assert property ($fell(rst) |->
    ##249 !ready_ff ##1 ready_ff) else $error("bad interval length");
  held_clr_a: assert property (!ready_ff |-> &pin_o_ff)
    else $error("cells not clear in interval");
  lock_cfg_a: assert property (fuse_ff && rd_cfg |=> rdata_ff == 8'h00)
    else $error("config readable when locked");
  lock_vfy_a: assert property (fuse_ff && rd_vfy |=> rdata_ff == 8'h00)
    else $error("verify readable when locked");
  st_fuse_a: assert property (rd_st |=> rdata_ff[1] == $past(fuse_ff))
    else $error("status fuse bit wrong");
  st_rdy_a: assert property (rd_st |=> rdata_ff[0] == $past(ready_ff))
    else $error("status ready bit wrong");
  cover property (ctl_wr && wdata[0]);
  cover property (wr && addr == mcl_pkg::ADDR_PRELOAD);
  cover property (rd && addr >= mcl_pkg::ADDR_SIG_BASE);
endmodule : mcl_checker

bind mcl_top mcl_checker #(.N(N)) i_chk (.clk, .rst, .addr, .wdata, .wr,
  .rd, .rdata_ff, .pin_o_ff, .pin_oe_ff, .fb_ff, .ready_ff);

// ### verification/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the macrocell block
module testbench;
  logic       clk, rst, wr, rd, oe_n, ready_ff;
  logic [3:0] addr;
  logic [7:0] wdata, rdata_ff, sum_term, pt_oe, drv_en, drv_val;
  logic [7:0] pin_i, pin_drv, pin_o_ff, pin_oe_ff, fb_ff;
  int         err_count = 0;
  int         check_count = 0;
  int         cyc_count = 0;

  mcl_top i_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_ff, .sum_term,
    .pt_oe, .oe_n, .pin_i, .pin_drv, .pin_o_ff, .pin_oe_ff, .fb_ff,
    .ready_ff);
  mcl_board i_board (.drv_en, .drv_val, .pin_o_ff, .pin_oe_ff, .pin_i,
    .pin_drv);

  // ==========================================================
  // Clock, hang guard and shared tasks
  always #2 clk = ~clk;
  // Ceiling covers two reset intervals plus traffic
  always @(posedge clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // inputs change only after an edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata_ff);
  endtask : rd_chk
  task automatic do_reset();
    int n = 0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 chk("pin_o", 8'hff, pin_o_ff);
    chk("pin_oe", 8'h00, pin_oe_ff);
    while (ready_ff !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk("interval", 8'(mcl_pkg::RST_CYCLES), 8'(n));
  endtask : do_reset

  // ==========================================================
  // Scenarios
  // signature bytes back
  task automatic t_sig();
    for (int i = 0; i < 8; i++) begin
      wr_reg(mcl_pkg::ADDR_SIG_BASE + 4'(i), 8'(8'h11 * (i + 1)));
    end
    for (int i = 0; i < 8; i++) begin
      rd_chk(mcl_pkg::ADDR_SIG_BASE + 4'(i), 8'(8'h11 * (i + 1)));
    end
  endtask : t_sig
  task automatic t_pre();
    @(posedge clk);
    oe_n <= 1'b0;
    sum_term <= 8'h3c;
    wr <= 1'b1;
    addr <= mcl_pkg::ADDR_PRELOAD;
    wdata <= 8'ha5;
    // Read straight after, before the next clock reloads the cells
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= mcl_pkg::ADDR_VERIFY;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("preload", 8'ha5, rdata_ff);
    tick(2);
    chk("reg_o", 8'hc3, pin_o_ff);
    chk("reg_oe", 8'hff, pin_oe_ff);
    rd_chk(mcl_pkg::ADDR_VERIFY, 8'h3c);
    @(posedge clk);
    oe_n <= 1'b1;
    tick(2);
    chk("reg_oe_off", 8'h00, pin_oe_ff);
  endtask : t_pre
  task automatic t_comb();
    // Upper cells output-only, lower cells enabled by product term
    wr_reg(mcl_pkg::ADDR_CFG, 8'haa);
    wr_reg(mcl_pkg::ADDR_CFG, 8'h55);
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h20);
    @(posedge clk);
    pt_oe <= 8'h05;
    sum_term <= 8'h5a;
    tick(3);
    chk("comb_oe", 8'hf5, pin_oe_ff);
    chk("comb_o", 8'h5a, pin_o_ff);
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h30);
    rd_chk(mcl_pkg::ADDR_CTRL, 8'h20);
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h10);
    rd_chk(mcl_pkg::ADDR_CTRL, 8'h10);
    wr_reg(mcl_pkg::ADDR_CFG, 8'hff);
    wr_reg(mcl_pkg::ADDR_CFG, 8'hff);
    @(posedge clk);
    drv_en <= 8'h0f;
    drv_val <= 8'h05;
    tick(3);
    chk("in_oe", 8'h00, pin_oe_ff);
    chk("in_fb", 8'hf5, fb_ff);
    rd_chk(mcl_pkg::ADDR_CFG, 8'hff);
  endtask : t_comb
  task automatic t_fuse();
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h01);
    rd_chk(mcl_pkg::ADDR_STATUS, 8'h03);
    rd_chk(mcl_pkg::ADDR_CFG, 8'h00);
    rd_chk(mcl_pkg::ADDR_VERIFY, 8'h00);
    rd_chk(mcl_pkg::ADDR_SIG_BASE + 4'h2, 8'h33);
    do_reset();
    // Refused preload leaves pads on the inverted sum term
    wr_reg(mcl_pkg::ADDR_PRELOAD, 8'h0f);
    #1 chk("lock_pre", 8'ha5, pin_o_ff);
    rd_chk(mcl_pkg::ADDR_STATUS, 8'h03);
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h02);
    rd_chk(mcl_pkg::ADDR_STATUS, 8'h01);
  endtask : t_fuse
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    {clk, rst, wr, rd, oe_n} = 5'b01001;
    {addr, wdata, sum_term, pt_oe, drv_en, drv_val} = '0;
    do_reset();
    wr_reg(mcl_pkg::ADDR_CTRL, 8'h02);
    rd_chk(mcl_pkg::ADDR_STATUS, 8'h01);
    t_sig();
    t_pre();
    t_comb();
    t_fuse();
    stop_test();
  end
endmodule : testbench
